// >>> core/npx_regs.svh
// constants shared by both ends of the nc/plc i/o image exchange
`ifndef NPX_REGS_SVH
`define NPX_REGS_SVH
`define NPX_BUF_BYTES 16384
`define NPX_AW 14
`define NPX_TW 16
`define NPX_PLC_IMG_BYTES 1024
`define NPX_PLC_AW 10
`define NPX_ORDER_LE 1'b0
`define NPX_ORDER_BE 1'b1
`define NPX_AREA_IN 1'b0
`define NPX_AREA_OUT 1'b1
`define NPX_LAST_LEFT 14'h0001
`define NPX_BYTE_SHIFT 3'h0
`endif

// >>> core/npx_pkg.sv
// types shared by both ends of the nc/plc i/o image exchange
`include "npx_regs.svh"
package npx_pkg;
   // item kinds addressed by byte offset
   typedef enum logic [1:0] {
      kind_byte = 2'h0,
      kind_word = 2'h1,
      kind_double = 2'h3,
      kind_real = 2'h2
   } npx_kind_e;
   // core item access sequencer
   typedef enum logic {
      acc_idle = 1'b0,
      acc_move = 1'b1
   } npx_acc_e;
   typedef logic [`NPX_AW-1:0] npx_addr_t;
   typedef logic [`NPX_TW-1:0] npx_time_t;
endpackage : npx_pkg

// >>> core/npx_link_if.sv
// link between the control core end and the logic controller end
`timescale 1ns/1ps
`default_nettype none
`include "npx_regs.svh"
interface npx_link_if;
   logic io_ok;
   logic in_req;
   logic [`NPX_AW-1:0] in_addr;
   logic [`NPX_AW-1:0] in_count;
   logic in_valid;
   logic [7:0] in_data;
   logic out_valid;
   logic [`NPX_AW-1:0] out_addr;
   logic [7:0] out_data;
   logic out_last;
   modport nc (
      input io_ok, in_valid, in_data,
      output in_req, in_addr, in_count, out_valid, out_addr, out_data, out_last
   );
   modport plc (
      output io_ok, in_valid, in_data,
      input in_req, in_addr, in_count, out_valid, out_addr, out_data, out_last
   );
endinterface : npx_link_if
`default_nettype wire

// >>> core/npx_plc_end.sv
// logic controller end: input image source and output module feed
`timescale 1ns/1ps
`default_nettype none
`include "npx_regs.svh"
module npx_plc_end (
   // clock and reset
   input wire logic clk,
   input wire logic reset,
   // link to the control core
   npx_link_if.plc link,
   // status of the attached i/o
   input wire logic io_error_free,
   // input image loading from the input modules
   input wire logic img_we,
   input wire logic [`NPX_PLC_AW-1:0] img_addr,
   input wire logic [7:0] img_data,
   // feed to the output modules
   output logic mod_valid,
   output logic [`NPX_AW-1:0] mod_addr,
   output logic [7:0] mod_data,
   output logic mod_frame_end
);
   import npx_pkg::*;

   logic [7:0] img_mem [`NPX_PLC_IMG_BYTES];
   logic io_s1_q;
   logic io_s2_q;
   logic io_s3_q;
   logic io_ok_q;
   logic in_valid_q;
   logic [7:0] in_data_q;
   npx_addr_t rd_ptr_q;
   npx_addr_t rd_left_q;
   logic mod_valid_q;
   npx_addr_t mod_addr_q;
   logic [7:0] mod_data_q;
   logic mod_end_q;

   // report attached i/o health to the core; the status pin is synchronised
   // through three flops and only taken once the last two agree
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         io_s1_q <= 1'b0;
         io_s2_q <= 1'b0;
         io_s3_q <= 1'b0;
         io_ok_q <= 1'b0;
      end else begin
         io_s1_q <= io_error_free;
         io_s2_q <= io_s1_q;
         io_s3_q <= io_s2_q;
         if (io_s2_q == io_s3_q) begin
            io_ok_q <= io_s3_q;
         end
      end
   end

   // input image storage
   always_ff @(posedge clk) begin
      if (img_we) begin
         img_mem[img_addr] <= img_data;
      end
   end

   // answer a refresh request with one contiguous run of bytes
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         rd_ptr_q <= '0;
         rd_left_q <= '0;
         in_valid_q <= 1'b0;
         in_data_q <= 8'h00;
      end else begin
         in_valid_q <= 1'b0;
         if (link.in_req) begin
            rd_ptr_q <= link.in_addr;
            rd_left_q <= link.in_count;
         end else if (rd_left_q != '0) begin
            in_valid_q <= 1'b1;
            in_data_q <= img_mem[rd_ptr_q[`NPX_PLC_AW-1:0]];
            rd_ptr_q <= rd_ptr_q + `NPX_AW'(1);
            rd_left_q <= rd_left_q - `NPX_AW'(1);
         end
      end
   end

   // pass core output bytes straight to the modules; own program stays off them
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         mod_valid_q <= 1'b0;
         mod_addr_q <= '0;
         mod_data_q <= 8'h00;
         mod_end_q <= 1'b0;
      end else begin
         mod_valid_q <= link.out_valid;
         mod_addr_q <= link.out_addr;
         mod_data_q <= link.out_data;
         mod_end_q <= link.out_valid & link.out_last;
      end
   end

   assign link.io_ok = io_ok_q;
   assign link.in_valid = in_valid_q;
   assign link.in_data = in_data_q;
   assign mod_valid = mod_valid_q;
   assign mod_addr = mod_addr_q;
   assign mod_data = mod_data_q;
   assign mod_frame_end = mod_end_q;
endmodule : npx_plc_end
`default_nettype wire

// >>> core/npx_nc_end.sv
// control core end: exchange buffer, item access, output push, input refresh
`timescale 1ns/1ps
`default_nettype none
`include "npx_regs.svh"
module npx_nc_end (
   // clock and reset
   input wire logic clk,
   input wire logic reset,
   // link to the logic controller
   npx_link_if.nc link,
   // configuration
   input wire npx_pkg::npx_addr_t cfg_in_count,
   input wire npx_pkg::npx_addr_t cfg_out_count,
   input wire npx_pkg::npx_addr_t input_area_start_address,
   input wire npx_pkg::npx_addr_t output_area_start_address,
   input wire npx_pkg::npx_time_t cfg_refresh_period,
   input wire npx_pkg::npx_time_t cfg_ipo_length,
   input wire logic cfg_byte_order,
   // interpolator timing
   input wire logic ipo_tick,
   // item access from the channel
   input wire logic acc_req,
   input wire logic acc_write,
   input wire logic acc_area,
   input wire npx_pkg::npx_kind_e acc_kind,
   input wire npx_pkg::npx_addr_t acc_offset,
   input wire logic [31:0] acc_wdata,
   output logic acc_ack,
   output logic acc_err,
   output logic [31:0] acc_rdata,
   output logic lookahead_stall,
   // status
   output logic io_started
);
   import npx_pkg::*;

   // last byte index of an item
   function automatic logic [1:0] size_m1(input npx_kind_e k);
      unique case (k)
         kind_byte: size_m1 = 2'h0;
         kind_word: size_m1 = 2'h1;
         kind_double: size_m1 = 2'h3;
         kind_real: size_m1 = 2'h3;
      endcase
   endfunction : size_m1

   // byte lane of the idx-th address of an item
   function automatic logic [1:0] lane_of(input logic ord, input logic [1:0] sm1,
                                          input logic [1:0] idx);
      lane_of = (ord == `NPX_ORDER_BE) ? sm1 - idx : idx;
   endfunction : lane_of

   logic [7:0] buf_mem [`NPX_BUF_BYTES];
   npx_acc_e st_q;
   npx_addr_t base_q;
   logic [1:0] sm1_q;
   logic [1:0] idx_q;
   logic wr_q;
   logic ord_q;
   logic [31:0] wdata_q;
   logic [31:0] rdata_q;
   logic ack_q;
   logic err_q;
   logic stall_q;
   logic started_q;
   logic written_q;
   logic out_busy_q;
   npx_addr_t out_ptr_q;
   npx_addr_t out_left_q;
   logic out_valid_q;
   npx_addr_t out_addr_q;
   logic [7:0] out_data_q;
   logic out_last_q;
   logic [`NPX_TW:0] acc_t_q;
   logic in_req_q;
   npx_addr_t in_addr_q;
   npx_addr_t in_count_q;
   npx_addr_t in_ptr_q;
   npx_addr_t in_left_q;

   logic [1:0] req_sm1_w;
   npx_addr_t area_count_w;
   npx_addr_t area_start_w;
   logic bad_w;
   npx_addr_t addr_w;
   logic [4:0] bit_w;
   logic in_take_w;
   logic core_wr_w;
   logic core_last_w;
   logic out_start_w;
   logic [`NPX_TW:0] sum_w;
   logic due_w;

   // request decode and bounds check against the area byte count
   assign req_sm1_w = size_m1(acc_kind);
   assign area_count_w = (acc_area == `NPX_AREA_OUT) ? cfg_out_count : cfg_in_count;
   assign area_start_w = (acc_area == `NPX_AREA_OUT) ? output_area_start_address
                                                     : input_area_start_address;
   assign bad_w = (acc_write && acc_area == `NPX_AREA_IN) ||
                  ({1'b0, acc_offset} + {13'h0000, req_sm1_w} >= {1'b0, area_count_w});
   assign addr_w = base_q + {12'h000, idx_q};
   assign bit_w = {lane_of(ord_q, sm1_q, idx_q), `NPX_BYTE_SHIFT};
   // incoming refresh bytes own the buffer write port; core writes wait
   assign in_take_w = link.in_valid && (in_left_q != '0);
   assign core_wr_w = (st_q == acc_move) && wr_q && !in_take_w;
   assign core_last_w = core_wr_w && (idx_q == sm1_q);
   assign out_start_w = ipo_tick && written_q && started_q && !out_busy_q &&
                        (cfg_out_count != '0);
   assign sum_w = acc_t_q + {1'b0, cfg_ipo_length};
   assign due_w = sum_w >= {1'b0, cfg_refresh_period};

   // item access sequencer, one byte per cycle
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         st_q <= acc_idle;
         base_q <= '0;
         sm1_q <= 2'h0;
         idx_q <= 2'h0;
         wr_q <= 1'b0;
         ord_q <= `NPX_ORDER_LE;
         wdata_q <= 32'h00000000;
         rdata_q <= 32'h00000000;
         ack_q <= 1'b0;
         err_q <= 1'b0;
         stall_q <= 1'b0;
      end else begin
         ack_q <= 1'b0;
         unique case (st_q)
            acc_idle: begin
               if (acc_req && bad_w) begin
                  ack_q <= 1'b1;
                  err_q <= 1'b1;
               end else if (acc_req) begin
                  st_q <= acc_move;
                  base_q <= area_start_w + acc_offset;
                  sm1_q <= req_sm1_w;
                  idx_q <= 2'h0;
                  wr_q <= acc_write;
                  ord_q <= cfg_byte_order;
                  wdata_q <= acc_wdata;
                  rdata_q <= 32'h00000000;
                  err_q <= 1'b0;
                  stall_q <= !acc_write;
               end
            end
            acc_move: begin
               if (!(wr_q && in_take_w)) begin
                  if (!wr_q) begin
                     rdata_q[bit_w +: 8] <= buf_mem[addr_w];
                  end
                  idx_q <= idx_q + 2'h1;
                  if (idx_q == sm1_q) begin
                     st_q <= acc_idle;
                     ack_q <= 1'b1;
                     stall_q <= 1'b0;
                  end
               end
            end
         endcase
      end
   end

   // exchange buffer writes: refresh bytes first, then core items
   always_ff @(posedge clk) begin
      if (in_take_w) begin
         buf_mem[in_ptr_q] <= link.in_data;
      end else if (core_wr_w) begin
         buf_mem[addr_w] <= wdata_q[bit_w +: 8];
      end
   end

   // startup gate and written-in-this-cycle flag; a late write survives the push
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         started_q <= 1'b0;
         written_q <= 1'b0;
      end else begin
         started_q <= started_q | link.io_ok;
         written_q <= (written_q & !out_start_w) | core_last_w;
      end
   end

   // output push of the whole configured area
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         out_busy_q <= 1'b0;
         out_ptr_q <= '0;
         out_left_q <= '0;
         out_valid_q <= 1'b0;
         out_addr_q <= '0;
         out_data_q <= 8'h00;
         out_last_q <= 1'b0;
      end else begin
         out_valid_q <= 1'b0;
         out_last_q <= 1'b0;
         if (out_start_w) begin
            out_busy_q <= 1'b1;
            out_ptr_q <= output_area_start_address;
            out_left_q <= cfg_out_count;
         end else if (out_busy_q) begin
            out_valid_q <= 1'b1;
            out_addr_q <= out_ptr_q;
            out_data_q <= buf_mem[out_ptr_q];
            out_last_q <= out_left_q == `NPX_LAST_LEFT;
            out_ptr_q <= out_ptr_q + `NPX_AW'(1);
            out_left_q <= out_left_q - `NPX_AW'(1);
            if (out_left_q == `NPX_LAST_LEFT) begin
               out_busy_q <= 1'b0;
            end
         end
      end
   end

   // input refresh timing and reception
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         acc_t_q <= '0;
         in_req_q <= 1'b0;
         in_addr_q <= '0;
         in_count_q <= '0;
         in_ptr_q <= '0;
         in_left_q <= '0;
      end else begin
         in_req_q <= 1'b0;
         if (ipo_tick && due_w) begin
            acc_t_q <= '0;
            if (started_q && in_left_q == '0 && cfg_in_count != '0) begin
               in_req_q <= 1'b1;
               in_addr_q <= input_area_start_address;
               in_count_q <= cfg_in_count;
               in_ptr_q <= input_area_start_address;
               in_left_q <= cfg_in_count;
            end
         end else if (ipo_tick) begin
            acc_t_q <= sum_w;
         end
         if (in_take_w) begin
            in_ptr_q <= in_ptr_q + `NPX_AW'(1);
            in_left_q <= in_left_q - `NPX_AW'(1);
         end
      end
   end

   assign link.in_req = in_req_q;
   assign link.in_addr = in_addr_q;
   assign link.in_count = in_count_q;
   assign link.out_valid = out_valid_q;
   assign link.out_addr = out_addr_q;
   assign link.out_data = out_data_q;
   assign link.out_last = out_last_q;
   assign acc_ack = ack_q;
   assign acc_err = err_q;
   assign acc_rdata = rdata_q;
   assign lookahead_stall = stall_q;
   assign io_started = started_q;
endmodule : npx_nc_end
`default_nettype wire

// >>> testbench/npx_link_chk.sv
// assertions on the link between the two exchange ends
`timescale 1ns/1ps
`default_nettype none
`include "npx_regs.svh"
module npx_link_chk (
   // clock and reset
   input wire logic clk,
   input wire logic reset,
   // link signals
   input wire logic io_ok,
   input wire logic in_req,
   input wire logic [`NPX_AW-1:0] in_addr,
   input wire logic [`NPX_AW-1:0] in_count,
   input wire logic in_valid,
   input wire logic [7:0] in_data,
   input wire logic out_valid,
   input wire logic [`NPX_AW-1:0] out_addr,
   input wire logic [7:0] out_data,
   input wire logic out_last
);
   logic seen_ok_q;
   logic [`NPX_AW-1:0] cnt_q;
   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);
   // remembers that the i/o was once reported healthy
   always_ff @(posedge clk or posedge reset) begin
      if (reset) seen_ok_q <= 1'b0;
      else if (io_ok) seen_ok_q <= 1'b1;
   end
   // counts refresh bytes since the last request
   always_ff @(posedge clk or posedge reset) begin
      if (reset) cnt_q <= 14'h0;
      else if (in_req) cnt_q <= 14'h0;
      else if (in_valid) cnt_q <= cnt_q + 14'h1;
   end
   a_push_gated: assert property (out_valid |-> seen_ok_q)
      else $error("output byte before the i/o was healthy");
   a_refresh_gated: assert property (in_req |-> seen_ok_q)
      else $error("refresh request before the i/o was healthy");
   a_addr_ascend: assert property (out_valid && !out_last |=>
      out_valid && out_addr == $past(out_addr) + 14'h1)
      else $error("output burst broken or not ascending");
   a_last_closes: assert property (out_last |-> out_valid ##1 !out_valid)
      else $error("final output byte misplaced");
   a_req_single: assert property (in_req |=> !in_req)
      else $error("refresh request longer than one cycle");
   a_req_hold: assert property (in_req |=> $stable(in_addr) && $stable(in_count))
      else $error("refresh address or count not held");
   a_reply_start: assert property (in_req |-> ##[2:3] in_valid)
      else $error("refresh bytes did not start");
   a_reply_count: assert property ($fell(in_valid) |-> cnt_q == in_count)
      else $error("refresh burst length differs from count");
   a_reply_bound: assert property (in_valid |-> cnt_q < in_count)
      else $error("refresh byte beyond the count");
endmodule : npx_link_chk
`default_nettype wire

// >>> testbench/testbench.sv
// self-checking bench for both ends of the nc/plc i/o image exchange
`timescale 1ns/1ps
`default_nettype none
`include "npx_regs.svh"
module testbench;
   import npx_pkg::*;
   logic clk = 1'b0;
   logic reset = 1'b1;
   logic io_error_free = 1'b0;
   logic img_we = 1'b0;
   logic [9:0] img_addr = 10'h0;
   logic [7:0] img_data = 8'h0;
   npx_addr_t cfg_in_count = 14'hb;
   npx_addr_t cfg_out_count = 14'h3;
   npx_addr_t input_area_start_address = 14'h1a4;
   npx_addr_t output_area_start_address = 14'h209; // areas kept apart
   npx_time_t cfg_refresh_period = 16'h0;
   npx_time_t cfg_ipo_length = 16'hc;
   logic cfg_byte_order = 1'b0;
   logic ipo_tick = 1'b0;
   logic acc_req = 1'b0;
   logic acc_write = 1'b0;
   logic acc_area = 1'b0;
   npx_kind_e acc_kind = kind_byte;
   npx_addr_t acc_offset = 14'h0;
   logic [31:0] acc_wdata = 32'h0;
   logic acc_ack, acc_err, lookahead_stall, io_started, mod_valid, mod_frame_end;
   logic [31:0] acc_rdata;
   logic [13:0] mod_addr;
   logic [7:0] mod_data;
   logic [7:0] mod_img [0:16383];
   int mod_bytes = 0, frames = 0, reqs = 0, fails = 0, tests_run = 0;
   npx_link_if link ();
   npx_nc_end npx_nc_end_inst (.clk(clk), .reset(reset), .link(link.nc),
      .cfg_in_count(cfg_in_count), .cfg_out_count(cfg_out_count),
      .input_area_start_address(input_area_start_address),
      .output_area_start_address(output_area_start_address),
      .cfg_refresh_period(cfg_refresh_period), .cfg_ipo_length(cfg_ipo_length),
      .cfg_byte_order(cfg_byte_order), .ipo_tick(ipo_tick), .acc_req(acc_req),
      .acc_write(acc_write), .acc_area(acc_area), .acc_kind(acc_kind),
      .acc_offset(acc_offset), .acc_wdata(acc_wdata), .acc_ack(acc_ack), .acc_err(acc_err),
      .acc_rdata(acc_rdata), .lookahead_stall(lookahead_stall), .io_started(io_started));
   npx_plc_end npx_plc_end_inst (.clk(clk), .reset(reset), .link(link.plc),
      .io_error_free(io_error_free), .img_we(img_we), .img_addr(img_addr),
      .img_data(img_data), .mod_valid(mod_valid), .mod_addr(mod_addr),
      .mod_data(mod_data), .mod_frame_end(mod_frame_end));
   npx_link_chk npx_link_chk_inst (.clk(clk), .reset(reset), .io_ok(link.io_ok),
      .in_req(link.in_req), .in_addr(link.in_addr), .in_count(link.in_count),
      .in_valid(link.in_valid), .in_data(link.in_data), .out_valid(link.out_valid),
      .out_addr(link.out_addr), .out_data(link.out_data), .out_last(link.out_last));
   // free-running clock
   always #4 clk = ~clk;
   // records output module traffic and refresh requests
   always @(posedge clk) begin
      if (mod_valid === 1'b1) begin
         mod_img[mod_addr] = mod_data;
         mod_bytes++;
      end
      if (mod_frame_end === 1'b1) frames++;
      if (link.in_req === 1'b1) reqs++;
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         fails++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic tick();
      @(posedge clk) #1 ipo_tick = 1'b1;
      @(posedge clk) #1 ipo_tick = 1'b0;
      repeat (25) @(posedge clk);
      #1;
   endtask : tick
   task automatic load(input logic [9:0] ad, input logic [7:0] d);
      @(posedge clk) #1 img_we = 1'b1;
      img_addr = ad;
      img_data = d;
      @(posedge clk) #1 img_we = 1'b0;
   endtask : load
   // one item access; judges stall, ack, error and read data
   task automatic acc(input logic w, input logic a, input npx_kind_e k, input npx_addr_t off,
      input logic [31:0] wd, input logic bo, input logic ee, input logic [31:0] er);
      int n;
      @(posedge clk) #1 acc_req = 1'b1;
      acc_write = w;
      acc_area = a;
      acc_kind = k;
      acc_offset = off;
      acc_wdata = wd;
      cfg_byte_order = bo;
      @(posedge clk) #1 acc_req = 1'b0;
      if (!ee) chk(lookahead_stall, !w);
      n = 0;
      while (acc_ack !== 1'b1 && n < 20) begin
         @(posedge clk) #1;
         n++;
      end
      chk(acc_ack, 1'b1);
      chk(lookahead_stall, 1'b0);
      chk(acc_err, ee);
      if (!w && !ee) chk(acc_rdata, er);
   endtask : acc
   task automatic t_gate();
      acc(1'b1, `NPX_AREA_OUT, kind_byte, 14'h2, 32'h7b, 1'b0, 1'b0, 32'h0);
      tick();
      chk(frames, 0);
      chk(reqs, 0);
      io_error_free = 1'b1;
      repeat (6) @(posedge clk);
      #1;
      chk(io_started, 1'b1);
      tick();
      chk(frames, 1);
      chk(mod_bytes, 3);
      chk(mod_img[523], 8'h7b);
   endtask : t_gate
   task automatic t_order();
      acc(1'b1, `NPX_AREA_OUT, kind_word, 14'h1, 32'habcd, 1'b1, 1'b0, 32'h0);
      tick();
      chk(mod_img[522], 8'hab);
      chk(mod_img[523], 8'hcd);
      acc(1'b1, `NPX_AREA_OUT, kind_double, 14'h0, 32'h0, 1'b0, 1'b1, 32'h0);
      acc(1'b1, `NPX_AREA_OUT, kind_real, 14'h0, 32'h0, 1'b0, 1'b1, 32'h0);
      acc(1'b1, `NPX_AREA_OUT, kind_word, 14'h2, 32'h0, 1'b0, 1'b1, 32'h0);
      acc(1'b1, `NPX_AREA_OUT, kind_byte, 14'h3, 32'h0, 1'b0, 1'b1, 32'h0);
      acc(1'b1, `NPX_AREA_OUT, kind_word, 14'h0, 32'h5566, 1'b0, 1'b0, 32'h0);
      acc(1'b0, `NPX_AREA_OUT, kind_word, 14'h0, 32'h0, 1'b0, 1'b0, 32'h5566);
      tick();
      chk(mod_img[521], 8'h66);
      chk(mod_img[522], 8'h55);
      chk(mod_bytes, 9);
      tick();
      chk(frames, 3);
   endtask : t_order
   task automatic t_refresh();
      int r0;
      r0 = reqs;
      tick();
      chk(reqs, r0 + 1);
      acc(1'b0, `NPX_AREA_IN, kind_word, 14'h0, 32'h0, 1'b1, 1'b0, 32'h4041);
      acc(1'b0, `NPX_AREA_IN, kind_double, 14'h2, 32'h0, 1'b0, 1'b0, 32'h45444342);
      acc(1'b0, `NPX_AREA_IN, kind_real, 14'h6, 32'h0, 1'b1, 1'b0, 32'h46474849);
      acc(1'b0, `NPX_AREA_IN, kind_double, 14'h7, 32'h0, 1'b1, 1'b0, 32'h4748494a);
      acc(1'b0, `NPX_AREA_IN, kind_double, 14'h8, 32'h0, 1'b1, 1'b1, 32'h0);
      acc(1'b1, `NPX_AREA_IN, kind_byte, 14'h0, 32'h1, 1'b0, 1'b1, 32'h0);
      load(10'h1ae, 8'h5a);
      acc(1'b0, `NPX_AREA_IN, kind_byte, 14'ha, 32'h0, 1'b0, 1'b0, 32'h4a);
      tick();
      acc(1'b0, `NPX_AREA_IN, kind_byte, 14'ha, 32'h0, 1'b0, 1'b0, 32'h5a);
      cfg_refresh_period = 16'h1e;
      r0 = reqs;
      repeat (6) tick();
      chk(reqs, r0 + 2);
   endtask : t_refresh
   task automatic tally_and_finish();
      $display("Checks run: %0d, mismatches: %0d", tests_run, fails);
      if (fails == 0 && tests_run > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask : tally_and_finish
   // main sequence: reset, image load, scenarios
   initial begin
      repeat (10) @(posedge clk);
      #1 reset = 1'b0;
      for (int i = 0; i < 11; i++) load(10'h1a4 + 10'(i), 8'h40 + 8'(i));
      t_gate();
      t_order();
      t_refresh();
      tally_and_finish();
   end
   // watchdog against a hung handshake
   initial begin
      #100000;
      fails++;
      tally_and_finish();
   end
endmodule : testbench
`default_nettype wire
